// *** design/urx_pkg.sv ***
// Constants, field positions and types for the serial receive channel.
// Assumes a 40 MHz system clock; no other package is needed.
package urx_pkg;
	// Mode word layout
	localparam int MODE_W         = 16;
	localparam int SYNC_BIT       = 7;
	localparam int CLKSEL_LO      = 4;
	localparam int CLKSEL_EXT_BIT = 1;
	localparam int CHRL_LO        = 0;
	localparam int PAR_LO         = 9;
	localparam int PAR_NONE_BIT   = 2;
	// Widths and depths
	localparam int CD_W       = 16;
	localparam int TO_W       = 8;
	localparam int TO_CNT_W   = 10;
	localparam int DATA_W     = 8;
	localparam int FIFO_DEPTH = 4;
	// Status vector layout
	localparam int ST_W       = 5;
	localparam int ST_RECEIVE_READY_FLAG   = 0;
	localparam int ST_OVERRUN = 1;
	localparam int ST_PARITY  = 2;
	localparam int ST_FRAME   = 3;
	localparam int ST_TIMEOUT = 4;
	// Clock sources and sampling
	localparam logic [1:0] SRC_MCLK_DIV  = 2'h1;
	localparam logic [2:0] PRESCALE_LAST = 3'h7;
	localparam int OVS           = 16;
	localparam int START_LOW_MIN = 7;
	localparam int FIRST_SAMPLE  = 24;
	localparam int TO_FACTOR     = 4;
	localparam int CHRL_BASE     = 5;
	localparam logic [3:0] OVS_LAST   = 4'(OVS - 1);
	localparam logic [3:0] START_LOW  = 4'(START_LOW_MIN);
	localparam logic [4:0] FIRST_WAIT = 5'(FIRST_SAMPLE - START_LOW_MIN);
	localparam logic [4:0] OVS_RELOAD = 5'(OVS);
	localparam logic [4:0] WAIT_ONE   = 5'h01;
	localparam logic [2:0] CHRL_LAST0 = 3'(CHRL_BASE - 1);
	localparam logic [TO_CNT_W-1:0] TO_ONE = 10'h001;
	// Check bit types
	localparam logic [1:0] PAR_EVEN  = 2'h0;
	localparam logic [1:0] PAR_ODD   = 2'h1;
	localparam logic [1:0] PAR_SPACE = 2'h2;
	localparam logic [1:0] PAR_MARK  = 2'h3;
	typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
endpackage

// *** design/fifo_if.sv ***
// Valid/ready channel between the receiver and its character queue.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface fifo_if #(parameter int W = 8);
	logic [W-1:0] wdata;
	logic         wvalid;
	logic         wready;
	logic [W-1:0] rdata;
	logic         rvalid;
	logic         rready;
	modport fifo (input wdata, input wvalid, output wready,
		output rdata, output rvalid, input rready);
	modport user (output wdata, output wvalid, input wready,
		input rdata, input rvalid, output rready);
endinterface

// *** design/rx_fifo.sv ***
// Small flip-flop queue with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, clock enable freezes it.
`timescale 1ns/10ps
module rx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clk_en,
	// Queue channel
	fifo_if.fifo     port
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW:0] EMPTY = '0;

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign port.wready = count_reg != FULL;
	assign port.rvalid = count_reg != EMPTY;
	assign port.rdata  = mem_reg[rd_ptr_reg];
	assign push        = port.wvalid && port.wready;
	assign pop         = port.rvalid && port.rready;

	// Storage needs no reset; count guards every read
	always_ff @(posedge clock)
	begin
		if (clk_en && push)
			mem_reg[wr_ptr_reg] <= port.wdata;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else if (clk_en)
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

	chk_fifo_no_overflow : assert property (@(posedge clock)
		disable iff (!arst_n) count_reg <= FULL)
		else $error("queue count beyond depth");
endmodule

// *** design/usart_rx.sv ***
// Bit clock generator, receiver, status flags and idle timer of one
// serial channel. Assumes configuration is quasi-static while a
// character is on the line, and command inputs are one-cycle pulses.
`timescale 1ns/10ps
module usart_rx (
	// Clock and reset
	input  wire logic                          clock,
	input  wire logic                          arst_n,
	input  wire logic                          clk_en,
	// Serial pins
	input  wire logic                          rx_line,
	input  wire logic                          serial_clk_in,
	// Configuration
	input  wire logic [urx_pkg::MODE_W-1:0]    mode_reg,
	input  wire logic [urx_pkg::CD_W-1:0]      baud_divisor_reg,
	input  wire logic [urx_pkg::TO_W-1:0]      idle_limit_reg,
	input  wire logic [urx_pkg::ST_W-1:0]      interrupt_mask_reg,
	// Commands
	input  wire logic                          restart_idle_wait_cmd,
	input  wire logic                          reset_status_cmd,
	input  wire logic                          holding_read,
	// Results
	output logic      [urx_pkg::DATA_W-1:0]    receive_holding_reg,
	output logic      [urx_pkg::ST_W-1:0]      channel_status_reg,
	output logic                               irq_reg
);
	urx_pkg::rx_state_t                 state_reg;
	logic                               rx_s1_reg;
	logic                               rx_s2_reg;
	logic                               rx_s3_reg;
	logic                               rx_filt_reg;
	logic                               sck_s1_reg;
	logic                               sck_s2_reg;
	logic                               sck_s3_reg;
	logic                               sck_filt_reg;
	logic                               sck_rise;
	logic [2:0]                         pre_reg;
	logic [urx_pkg::CD_W-1:0]           div_reg;
	logic [3:0]                         ovs_reg;
	logic [4:0]                         wait_reg;
	logic [3:0]                         low_cnt_reg;
	logic [2:0]                         bit_idx_reg;
	logic [urx_pkg::DATA_W-1:0]         data_reg;
	logic                               par_bit_reg;
	logic                               to_run_reg;
	logic [urx_pkg::TO_CNT_W-1:0]       to_cnt_reg;
	logic                               sync_mode;
	logic                               ext_sel;
	logic [1:0]                         clk_sel;
	logic [2:0]                         par_sel;
	logic [2:0]                         last_idx;
	logic                               has_parity;
	logic                               src_tick;
	logic                               div_tick;
	logic                               baud_tick;
	logic                               bit_period_tick;
	logic                               sample_now;
	logic                               char_done;
	logic                               par_expect;
	logic                               to_expire;
	logic [urx_pkg::TO_CNT_W-1:0]       to_load;
	logic [urx_pkg::ST_W-1:0]           status_set;
	logic [urx_pkg::ST_W-1:0]           status_clr;
	logic                               irq_cause;

	fifo_if #(.W(urx_pkg::DATA_W)) rx_q ();

	rx_fifo #(
		.WIDTH (urx_pkg::DATA_W),
		.DEPTH (urx_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock  (clock),
		.arst_n (arst_n),
		.clk_en (clk_en),
		.port   (rx_q.fifo)
	);

	// Mode decode
	assign sync_mode  = mode_reg[urx_pkg::SYNC_BIT];
	assign clk_sel    = mode_reg[urx_pkg::CLKSEL_LO +: 2];
	assign ext_sel    = clk_sel[urx_pkg::CLKSEL_EXT_BIT];
	assign par_sel    = mode_reg[urx_pkg::PAR_LO +: 3];
	assign has_parity = !par_sel[urx_pkg::PAR_NONE_BIT];
	assign last_idx   = urx_pkg::CHRL_LAST0 +
		3'(mode_reg[urx_pkg::CHRL_LO +: 2]);

	// Pins cross in three stages; a change counts once stages 2 and 3 agree
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_s1_reg    <= 1'b1;
			rx_s2_reg    <= 1'b1;
			rx_s3_reg    <= 1'b1;
			rx_filt_reg  <= 1'b1;
			sck_s1_reg   <= 1'b0;
			sck_s2_reg   <= 1'b0;
			sck_s3_reg   <= 1'b0;
			sck_filt_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			rx_s1_reg  <= rx_line;
			rx_s2_reg  <= rx_s1_reg;
			rx_s3_reg  <= rx_s2_reg;
			sck_s1_reg <= serial_clk_in;
			sck_s2_reg <= sck_s1_reg;
			sck_s3_reg <= sck_s2_reg;
			if (rx_s2_reg == rx_s3_reg)
				rx_filt_reg <= rx_s3_reg;
			if (sck_s2_reg == sck_s3_reg)
				sck_filt_reg <= sck_s3_reg;
		end
	end

	// Edge detection relies on the pin clock being slow enough
	assign sck_rise = (sck_s2_reg == sck_s3_reg) && sck_s3_reg
		&& !sck_filt_reg;

	// Source selection
	assign src_tick = ext_sel ? sck_rise :
		(clk_sel == urx_pkg::SRC_MCLK_DIV) ?
		(pre_reg == urx_pkg::PRESCALE_LAST) : 1'b1;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			pre_reg <= '0;
		else if (clk_en)
			pre_reg <= pre_reg + 1'b1;
	end

	// Divisor; zero stops the clock
	assign div_tick = src_tick && (baud_divisor_reg != '0)
		&& (div_reg >= baud_divisor_reg - 1'b1);

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			div_reg <= '0;
		else if (clk_en && src_tick && baud_divisor_reg != '0)
		begin
			if (div_tick)
				div_reg <= '0;
			else
				div_reg <= div_reg + 1'b1;
		end
	end

	// Sync with pin clock bypasses the divisor entirely
	assign baud_tick = (sync_mode && ext_sel) ? sck_rise : div_tick;

	// Async ticks are sixteenths of a bit
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			ovs_reg <= '0;
		else if (clk_en && baud_tick)
			ovs_reg <= ovs_reg + 1'b1;
	end

	assign bit_period_tick = sync_mode ? baud_tick :
		(baud_tick && ovs_reg == urx_pkg::OVS_LAST);
	assign sample_now = sync_mode ? baud_tick :
		(baud_tick && wait_reg == urx_pkg::WAIT_ONE);
	assign char_done = (state_reg == urx_pkg::RX_STOP) && sample_now;

	// Receiver sequencing
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg   <= urx_pkg::RX_IDLE;
			wait_reg    <= '0;
			low_cnt_reg <= '0;
			bit_idx_reg <= '0;
			data_reg    <= '0;
			par_bit_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (baud_tick && state_reg != urx_pkg::RX_IDLE)
				wait_reg <= (wait_reg == urx_pkg::WAIT_ONE) ?
					urx_pkg::OVS_RELOAD : wait_reg - 1'b1;
			unique case (state_reg)
				urx_pkg::RX_IDLE:
				begin
					bit_idx_reg <= '0;
					if (sync_mode)
					begin
						if (baud_tick && !rx_filt_reg)
						begin
							state_reg <= urx_pkg::RX_DATA;
							data_reg  <= '0;
						end
					end
					else if (baud_tick)
					begin
						if (rx_filt_reg)
							low_cnt_reg <= '0;
						else if (low_cnt_reg == urx_pkg::START_LOW)
						begin
							state_reg   <= urx_pkg::RX_DATA;
							wait_reg    <= urx_pkg::FIRST_WAIT;
							low_cnt_reg <= '0;
							data_reg    <= '0;
						end
						else
							low_cnt_reg <= low_cnt_reg + 1'b1;
					end
				end
				urx_pkg::RX_DATA:
				begin
					if (sample_now)
					begin
						data_reg[bit_idx_reg] <= rx_filt_reg;
						bit_idx_reg <= bit_idx_reg + 1'b1;
						if (bit_idx_reg == last_idx)
							state_reg <= has_parity ?
								urx_pkg::RX_PARITY : urx_pkg::RX_STOP;
					end
				end
				urx_pkg::RX_PARITY:
				begin
					if (sample_now)
					begin
						par_bit_reg <= rx_filt_reg;
						state_reg   <= urx_pkg::RX_STOP;
					end
				end
				urx_pkg::RX_STOP:
				begin
					if (sample_now)
						state_reg <= urx_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// Expected check bit
	always_comb
	begin
		unique case (par_sel[1:0])
			urx_pkg::PAR_EVEN:  par_expect = ^data_reg;
			urx_pkg::PAR_ODD:   par_expect = ~^data_reg;
			urx_pkg::PAR_SPACE: par_expect = 1'b0;
			urx_pkg::PAR_MARK:  par_expect = 1'b1;
		endcase
	end

	// Queue; the line cannot be stalled, so a full queue loses the byte
	assign rx_q.wvalid = char_done;
	assign rx_q.wdata  = data_reg;
	assign rx_q.rready = !channel_status_reg[urx_pkg::ST_RECEIVE_READY_FLAG]
		|| holding_read;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			receive_holding_reg <= '0;
		else if (clk_en && rx_q.rvalid && rx_q.rready)
			receive_holding_reg <= rx_q.rdata;
	end

	// Idle timer
	assign to_load   = urx_pkg::TO_CNT_W'(idle_limit_reg) *
		urx_pkg::TO_CNT_W'(urx_pkg::TO_FACTOR);
	assign to_expire = to_run_reg && bit_period_tick
		&& to_cnt_reg == urx_pkg::TO_ONE;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			to_run_reg <= 1'b0;
			to_cnt_reg <= '0;
		end
		else if (clk_en)
		begin
			if (restart_idle_wait_cmd || idle_limit_reg == '0)
				to_run_reg <= 1'b0;
			else if (char_done)
			begin
				to_run_reg <= 1'b1;
				to_cnt_reg <= to_load;
			end
			else if (to_run_reg && bit_period_tick)
			begin
				to_cnt_reg <= to_cnt_reg - 1'b1;
				if (to_expire)
					to_run_reg <= 1'b0;
			end
		end
	end

	// Flags: a set in the clearing cycle wins
	always_comb
	begin
		status_set = '0;
		status_clr = '0;
		status_set[urx_pkg::ST_RECEIVE_READY_FLAG]   = rx_q.rvalid && rx_q.rready;
		status_set[urx_pkg::ST_OVERRUN] = char_done && !rx_q.wready;
		status_set[urx_pkg::ST_PARITY]  = char_done && has_parity
			&& (par_expect != par_bit_reg);
		status_set[urx_pkg::ST_FRAME]   = char_done && !rx_filt_reg
			&& (|data_reg);
		status_set[urx_pkg::ST_TIMEOUT] = to_expire;
		status_clr[urx_pkg::ST_RECEIVE_READY_FLAG]   = holding_read;
		status_clr[urx_pkg::ST_OVERRUN] = reset_status_cmd;
		status_clr[urx_pkg::ST_PARITY]  = reset_status_cmd;
		status_clr[urx_pkg::ST_FRAME]   = reset_status_cmd;
		status_clr[urx_pkg::ST_TIMEOUT] = restart_idle_wait_cmd;
	end

	assign irq_cause = |(channel_status_reg & interrupt_mask_reg);

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			channel_status_reg <= '0;
			irq_reg            <= 1'b0;
		end
		else if (clk_en)
		begin
			channel_status_reg <= status_set |
				(channel_status_reg & ~status_clr);
			irq_reg <= irq_cause;
		end
	end

	chk_divisor_zero_stop : assert property (@(posedge clock)
		disable iff (!arst_n)
		(!(sync_mode && ext_sel) && baud_divisor_reg == '0) |-> !baud_tick)
		else $error("bit clock runs with zero divisor");

	chk_sync_pin_clock : assert property (@(posedge clock)
		disable iff (!arst_n)
		(sync_mode && ext_sel) |-> (baud_tick == sck_rise))
		else $error("sync pin clock not used directly");

	chk_start_low_count : assert property (@(posedge clock)
		disable iff (!arst_n)
		(state_reg == urx_pkg::RX_DATA && $past(state_reg) ==
		urx_pkg::RX_IDLE && !sync_mode) |->
		$past(low_cnt_reg) == urx_pkg::START_LOW && !$past(rx_filt_reg))
		else $error("start accepted without eight low samples");

	chk_first_sample_wait : assert property (@(posedge clock)
		disable iff (!arst_n)
		(state_reg == urx_pkg::RX_DATA && $past(state_reg) ==
		urx_pkg::RX_IDLE && !sync_mode) |-> wait_reg == urx_pkg::FIRST_WAIT)
		else $error("first sample not 24 ticks after edge");

	chk_ready_follows : assert property (@(posedge clock)
		disable iff (!arst_n)
		(char_done && rx_q.wready && clk_en) ##1 clk_en |=>
		channel_status_reg[urx_pkg::ST_RECEIVE_READY_FLAG])
		else $error("ready flag not set after character");

	chk_overrun_set : assert property (@(posedge clock)
		disable iff (!arst_n)
		(char_done && !rx_q.wready && clk_en) |=>
		channel_status_reg[urx_pkg::ST_OVERRUN])
		else $error("overrun not flagged");

	chk_parity_flag : assert property (@(posedge clock)
		disable iff (!arst_n)
		(char_done && clk_en && has_parity && par_expect != par_bit_reg)
		|=> channel_status_reg[urx_pkg::ST_PARITY])
		else $error("check bit error not flagged");

	chk_framing_flag : assert property (@(posedge clock)
		disable iff (!arst_n)
		(char_done && clk_en && !rx_filt_reg && |data_reg) |=>
		channel_status_reg[urx_pkg::ST_FRAME])
		else $error("framing error not flagged");

	chk_idle_off : assert property (@(posedge clock)
		disable iff (!arst_n)
		(idle_limit_reg == '0 && clk_en) |=> !to_run_reg)
		else $error("idle timer runs with zero limit");

	chk_idle_load : assert property (@(posedge clock)
		disable iff (!arst_n)
		(char_done && clk_en && idle_limit_reg != '0 &&
		!restart_idle_wait_cmd) |=>
		to_run_reg && to_cnt_reg == {$past(idle_limit_reg), 2'h0})
		else $error("idle timer load not four bits per unit");

	chk_irq_mask : assert property (@(posedge clock)
		disable iff (!arst_n)
		clk_en |=> irq_reg == $past(irq_cause))
		else $error("interrupt does not follow masked flags");
endmodule

// *** sim/serial_tx_model.sv ***
// Remote serial transmitter driving the receive line and serial clock.
// Assumes one shared system clock; the bench calls send and glitch.
`timescale 1ns/10ps
module serial_tx_model (
	// Clock
	input  wire logic clock,
	// Serial pins
	output logic      rx_line,
	output logic      serial_clk_in
);
	// Line idles high, pin clock stands low outside frames
	initial
	begin
		rx_line       = 1'b1;
		serial_clk_in = 1'b0;
	end

	// Pin clock halves of cyc cycles each, far slower than the system clock
	task automatic put_bit(input logic b, input int cyc, input bit ext);
	begin
		@(posedge clock);
		rx_line <= b;
		if (ext)
		begin
			repeat (cyc) @(posedge clock);
			serial_clk_in <= 1'b1;
			repeat (cyc) @(posedge clock);
			serial_clk_in <= 1'b0;
		end
		else
			repeat (cyc - 1) @(posedge clock);
	end
	endtask

	// Low stop is cut short so its tail cannot pass for a new start
	task automatic send(input logic [7:0] d, input int nb,
		input logic [2:0] par, input logic flip, input logic stop,
		input int cyc, input bit ext);
		logic x;
		logic p;
	begin
		x = ^(d & (8'hFF >> (8 - nb)));
		p = par[1] ? par[0] : (x ^ par[0]);
		put_bit(1'b0, cyc, ext);
		for (int i = 0; i < nb; i++)
			put_bit(d[i], cyc, ext);
		if (!par[2])
			put_bit(p ^ flip, cyc, ext);
		put_bit(stop, stop ? cyc : cyc * 5 / 8, ext);
		@(posedge clock);
		rx_line <= 1'b1;
	end
	endtask

	// Deliberately short space on the line
	task automatic glitch(input int n);
	begin
		@(posedge clock);
		rx_line <= 1'b0;
		repeat (n) @(posedge clock);
		rx_line <= 1'b1;
	end
	endtask
endmodule

// *** sim/usart_rx_test.sv ***
// Self-checking bench for the serial receive channel.
// Assumes the design files are compiled first; model drives the pins.
`timescale 1ns/10ps
module usart_rx_test;
	// Design signals
	logic        clock;
	logic        arst_n;
	logic        clk_en;
	logic        rx_line;
	logic        serial_clk_in;
	logic [15:0] mode_reg;
	logic [15:0] baud_divisor_reg;
	logic [7:0]  idle_limit_reg;
	logic [4:0]  interrupt_mask_reg;
	logic        restart_idle_wait_cmd;
	logic        reset_status_cmd;
	logic        holding_read;
	logic [7:0]  receive_holding_reg;
	logic [4:0]  channel_status_reg;
	logic        irq_reg;
	// Bench state
	int          err_count;
	int          checks;
	int          seed;
	int          dv;
	logic [7:0]  d;
	logic [7:0]  sent_q[$];

	usart_rx dut (
		.clock                 (clock),
		.arst_n                (arst_n),
		.clk_en                (clk_en),
		.rx_line               (rx_line),
		.serial_clk_in         (serial_clk_in),
		.mode_reg              (mode_reg),
		.baud_divisor_reg      (baud_divisor_reg),
		.idle_limit_reg        (idle_limit_reg),
		.interrupt_mask_reg    (interrupt_mask_reg),
		.restart_idle_wait_cmd (restart_idle_wait_cmd),
		.reset_status_cmd      (reset_status_cmd),
		.holding_read          (holding_read),
		.receive_holding_reg   (receive_holding_reg),
		.channel_status_reg    (channel_status_reg),
		.irq_reg               (irq_reg)
	);

	serial_tx_model tx (
		.clock         (clock),
		.rx_line       (rx_line),
		.serial_clk_in (serial_clk_in)
	);

	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	function automatic logic [7:0] exp_char(input logic [7:0] v,
		input int nb);
		return v & (8'hFF >> (8 - nb));
	endfunction

	function automatic logic [15:0] mode_word(input logic sy,
		input logic [1:0] src, input int nb, input logic [2:0] par);
		logic [15:0] m;
		m       = 16'h0000;
		m[1:0]  = 2'(nb - 5);
		m[5:4]  = src;
		m[7]    = sy;
		m[11:9] = par;
		return m;
	endfunction

	task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
	begin
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: data %h not %h", $time, got, exp);
		end
	end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
	begin
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: flag %b not %b", $time, got, exp);
		end
	end
	endtask

	task automatic cmp_flag(input int idx, input logic exp);
		cmp_bit(channel_status_reg[idx], exp);
	endtask

	task automatic give_verdict;
	begin
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask

	// 0 read, 1 clear status, 2 restart idle wait
	task automatic pulse(input int sel);
	begin
		@(posedge clock);
		holding_read          <= (sel == 0);
		reset_status_cmd      <= (sel == 1);
		restart_idle_wait_cmd <= (sel == 2);
		@(posedge clock);
		holding_read          <= 1'b0;
		reset_status_cmd      <= 1'b0;
		restart_idle_wait_cmd <= 1'b0;
	end
	endtask

	// Config changes only while the line is idle
	task automatic setup(input logic sy, input logic [1:0] src,
		input int nb, input logic [2:0] par, input logic [15:0] div,
		input logic [7:0] lim);
	begin
		@(posedge clock);
		mode_reg         <= mode_word(sy, src, nb, par);
		baud_divisor_reg <= div;
		idle_limit_reg   <= lim;
		repeat (4) @(posedge clock);
		pulse(1);
	end
	endtask

	task automatic wait_ready;
		int n;
	begin
		n = 0;
		while (channel_status_reg[urx_pkg::ST_RECEIVE_READY_FLAG] !== 1'b1 && n < 300)
		begin
			@(posedge clock);
			n++;
		end
	end
	endtask

	task automatic rx_one(input logic [7:0] v, input int nb,
		input logic [2:0] par, input logic flip, input logic stop,
		input int cyc, input bit ext);
	begin
		tx.send(v, nb, par, flip, stop, cyc, ext);
		wait_ready;
		cmp_flag(urx_pkg::ST_RECEIVE_READY_FLAG, 1'b1);
		cmp_data(receive_holding_reg, exp_char(v, nb));
		pulse(0);
	end
	endtask

	// Watchdog sized well above the roughly 12000 cycles of the tests
	initial
	begin
		repeat (80000) @(posedge clock);
		err_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		give_verdict;
	end

	initial
	begin
		seed                  = 32'ha6f9a864;
		err_count             = 0;
		checks                = 0;
		arst_n                = 1'b0;
		clk_en                = 1'b1;
		mode_reg              = 16'h0000;
		baud_divisor_reg      = 16'h0001;
		idle_limit_reg        = 8'h00;
		interrupt_mask_reg    = 5'h00;
		restart_idle_wait_cmd = 1'b0;
		reset_status_cmd      = 1'b0;
		holding_read          = 1'b0;
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		cmp_data({3'h0, channel_status_reg}, 8'h00);
		cmp_data(receive_holding_reg, 8'h00);
		for (int p = 0; p < 5; p++)
			for (int nb = 5; nb < 9; nb++)
			begin
				dv = 1 + (($random(seed) & 32'h7FFFFFFF) % 3);
				setup(1'b0, 2'h0, nb, 3'(p), 16'(dv), 8'h00);
				d = 8'($random(seed));
				rx_one(d, nb, 3'(p), 1'b0, 1'b1, 16 * dv, 1'b0);
				cmp_flag(urx_pkg::ST_PARITY, 1'b0);
				cmp_flag(urx_pkg::ST_FRAME, 1'b0);
			end
		$display("test formats done");
		setup(1'b0, 2'h0, 8, 3'h0, 16'h0001, 8'h00);
		rx_one(8'h5A, 8, 3'h0, 1'b1, 1'b1, 16, 1'b0);
		cmp_flag(urx_pkg::ST_PARITY, 1'b1);
		pulse(1);
		rx_one(8'h80, 8, 3'h0, 1'b0, 1'b0, 16, 1'b0);
		cmp_flag(urx_pkg::ST_FRAME, 1'b1);
		cmp_flag(urx_pkg::ST_PARITY, 1'b0);
		pulse(1);
		rx_one(8'h00, 8, 3'h0, 1'b0, 1'b0, 16, 1'b0);
		cmp_flag(urx_pkg::ST_FRAME, 1'b0);
		$display("test line errors done");
		setup(1'b0, 2'h0, 8, 3'h4, 16'h0002, 8'h00);
		tx.glitch(14);
		repeat (100) @(posedge clock);
		cmp_flag(urx_pkg::ST_RECEIVE_READY_FLAG, 1'b0);
		tx.glitch(20);
		wait_ready;
		cmp_data(receive_holding_reg, 8'hFF);
		pulse(0);
		$display("test start filter done");
		setup(1'b0, 2'h0, 8, 3'h4, 16'h0001, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			d = 8'($random(seed));
			sent_q.push_back(d);
			tx.send(d, 8, 3'h4, 1'b0, 1'b1, 16, 1'b0);
		end
		repeat (10) @(posedge clock);
		cmp_flag(urx_pkg::ST_OVERRUN, 1'b1);
		interrupt_mask_reg <= 5'h01;
		repeat (2) @(posedge clock);
		cmp_bit(irq_reg, 1'b1);
		interrupt_mask_reg <= 5'h00;
		repeat (2) @(posedge clock);
		cmp_bit(irq_reg, 1'b0);
		void'(sent_q.pop_back());
		while (sent_q.size() > 0)
		begin
			cmp_data(receive_holding_reg, sent_q.pop_front());
			pulse(0);
			repeat (2) @(posedge clock);
		end
		cmp_flag(urx_pkg::ST_RECEIVE_READY_FLAG, 1'b0);
		$display("test overrun done");
		setup(1'b0, 2'h0, 8, 3'h4, 16'h0000, 8'h00);
		tx.send(8'h33, 8, 3'h4, 1'b0, 1'b1, 16, 1'b0);
		setup(1'b1, 2'h0, 8, 3'h4, 16'h0000, 8'h00);
		tx.send(8'h33, 8, 3'h4, 1'b0, 1'b1, 4, 1'b0);
		repeat (60) @(posedge clock);
		cmp_flag(urx_pkg::ST_RECEIVE_READY_FLAG, 1'b0);
		setup(1'b0, 2'h1, 8, 3'h1, 16'h0001, 8'h00);
		rx_one(8'($random(seed)), 8, 3'h1, 1'b0, 1'b1, 128, 1'b0);
		setup(1'b1, 2'h0, 8, 3'h1, 16'h0004, 8'h00);
		for (int i = 0; i < 3; i++)
			rx_one(8'($random(seed)), 8, 3'h1, 1'b0, 1'b1, 4, 1'b0);
		cmp_flag(urx_pkg::ST_PARITY, 1'b0);
		setup(1'b1, 2'h2, 7, 3'h4, 16'h0000, 8'h00);
		for (int i = 0; i < 3; i++)
			rx_one(8'($random(seed)), 7, 3'h4, 1'b0, 1'b1, 4, 1'b1);
		$display("test clock sources done");
		setup(1'b0, 2'h0, 8, 3'h4, 16'h0001, 8'h02);
		interrupt_mask_reg <= 5'h10;
		rx_one(8'($random(seed)), 8, 3'h4, 1'b0, 1'b1, 16, 1'b0);
		repeat (90) @(posedge clock);
		cmp_flag(urx_pkg::ST_TIMEOUT, 1'b0);
		// Enable low must freeze the idle count
		clk_en <= 1'b0;
		repeat (100) @(posedge clock);
		cmp_flag(urx_pkg::ST_TIMEOUT, 1'b0);
		clk_en <= 1'b1;
		repeat (60) @(posedge clock);
		cmp_flag(urx_pkg::ST_TIMEOUT, 1'b1);
		cmp_bit(irq_reg, 1'b1);
		pulse(2);
		repeat (300) @(posedge clock);
		cmp_flag(urx_pkg::ST_TIMEOUT, 1'b0);
		setup(1'b0, 2'h0, 8, 3'h4, 16'h0001, 8'h00);
		rx_one(8'($random(seed)), 8, 3'h4, 1'b0, 1'b1, 16, 1'b0);
		repeat (300) @(posedge clock);
		cmp_flag(urx_pkg::ST_TIMEOUT, 1'b0);
		$display("test idle timer done");
		interrupt_mask_reg <= 5'h01;
		tx.send(8'hC3, 8, 3'h4, 1'b0, 1'b1, 16, 1'b0);
		wait_ready;
		fork
			tx.send(8'h0F, 8, 3'h4, 1'b0, 1'b1, 16, 1'b0);
		join_none
		repeat (60) @(posedge clock);
		arst_n <= 1'b0;
		repeat (2) @(posedge clock);
		cmp_data({3'h0, channel_status_reg}, 8'h00);
		cmp_bit(irq_reg, 1'b0);
		arst_n <= 1'b1;
		wait fork;
		$display("test reset done");
		give_verdict;
	end
endmodule
